// ===== common/cmp_pkg.sv
// Shared constants for the comparator control block
`default_nettype none
package cmp_pkg;
  // Register byte addresses on the Avalon-MM slave
  localparam logic [3:0] CONTROL_ADDR = 4'h0;
  localparam logic [3:0] MODE_ADDR    = 4'h4;
  // Control register fields
  localparam int CTL_EN_BIT    = 7;
  localparam int CTL_STATE_BIT = 6;
  localparam int CTL_RISE_BIT  = 5;
  localparam int CTL_FALL_BIT  = 4;
  localparam int CTL_HYP_LSB   = 2;
  localparam int CTL_HYN_LSB   = 0;
  // Mode register fields
  localparam int MD_RIE_BIT    = 5;
  localparam int MD_FIE_BIT    = 4;
  localparam int MD_RESP_LSB   = 0;
  // Values after reset
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] MODE_RST    = 8'h02;
  // Writable bits of each register; all others read zero except control bit 6, which reads the synchronised state
  localparam logic [7:0] CONTROL_WMASK = 8'hBF;
  localparam logic [7:0] MODE_WMASK    = 8'h33;
  // Synchroniser depth
  localparam int SYNC_STAGES = 2;

  // Hysteresis settings: disabled, 5, 10, 20 mV
  typedef enum logic [1:0] {
    HYST_OFF  = 2'b00,
    HYST_5MV  = 2'b01,
    HYST_10MV = 2'b10,
    HYST_20MV = 2'b11
  } hyst_sel_t;

  // Response time, fastest to slowest
  typedef enum logic [1:0] {
    RESP_FASTEST = 2'b00,
    RESP_FAST    = 2'b01,
    RESP_SLOW    = 2'b10,
    RESP_SLOWEST = 2'b11
  } resp_sel_t;
endpackage
`default_nettype wire

// ===== common/edge_if.sv
// Synchronised comparator sample and edge events
`default_nettype none
interface edge_if;
  logic sync_level;
  logic rise_pulse;
  logic fall_pulse;
  modport producer (output sync_level, output rise_pulse, output fall_pulse);
  modport consumer (input sync_level, input rise_pulse, input fall_pulse);
endinterface
`default_nettype wire

// ===== hdl/cmp_ctrl.sv
// Comparator control: registers, outputs, edge flags and interrupt request
`default_nettype none
module cmp_ctrl
  import cmp_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic [1:0]       avs_response_o,
  input  wire logic        cmp_result_i,
  output logic             cmp_power_en_o,
  output logic [1:0]       pos_hyst_sel_o,
  output logic [1:0]       neg_hyst_sel_o,
  output logic [1:0]       resp_time_sel_o,
  output logic             cmp_sync_out_o,
  output logic             cmp_raw_out_o,
  output logic             cmp_irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  logic            cmp_enable_bit_ff;
  logic [1:0]      pos_hyst_sel_ff;
  logic [1:0]      neg_hyst_sel_ff;
  logic            rise_irq_en_ff;
  logic            fall_irq_en_ff;
  logic [1:0]      resp_time_sel_ff;
  logic            ack_ff;
  logic [31:0]     rdata_ff;
  logic            rise_edge_flag;
  logic            fall_edge_flag;

  edge_if ev ();

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM decode: one wait cycle, answer on the second edge

  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    return a == r;
  endfunction

  wire req        = avs_read_i | avs_write_i;
  wire sel_ctl    = hit(avs_address_i, CONTROL_ADDR);
  wire sel_mode   = hit(avs_address_i, MODE_ADDR);
  wire mapped     = sel_ctl | sel_mode;
  wire wr_take    = avs_write_i & ack_ff & avs_byteenable_i[0];
  wire wr_ctl     = wr_take & sel_ctl;
  wire wr_mode    = wr_take & sel_mode;
  wire [7:0] wval = avs_writedata_i[7:0];

  assign avs_waitrequest_o = req & ~ack_ff;
  assign avs_response_o    = mapped ? 2'b00 : 2'b10;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and mode registers

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmp_enable_bit_ff <= CONTROL_RST[CTL_EN_BIT];
      pos_hyst_sel_ff   <= CONTROL_RST[CTL_HYP_LSB +: 2];
      neg_hyst_sel_ff   <= CONTROL_RST[CTL_HYN_LSB +: 2];
    end else if (wr_ctl) begin
      cmp_enable_bit_ff <= wval[CTL_EN_BIT];
      pos_hyst_sel_ff   <= wval[CTL_HYP_LSB +: 2];
      neg_hyst_sel_ff   <= wval[CTL_HYN_LSB +: 2];
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rise_irq_en_ff   <= MODE_RST[MD_RIE_BIT];
      fall_irq_en_ff   <= MODE_RST[MD_FIE_BIT];
      resp_time_sel_ff <= MODE_RST[MD_RESP_LSB +: 2];
    end else if (wr_mode) begin
      rise_irq_en_ff   <= wval[MD_RIE_BIT];
      fall_irq_en_ff   <= wval[MD_FIE_BIT];
      resp_time_sel_ff <= wval[MD_RESP_LSB +: 2];
    end
  end

  // Settings steer the analog front end
  assign cmp_power_en_o  = cmp_enable_bit_ff;
  assign pos_hyst_sel_o  = pos_hyst_sel_ff;
  assign neg_hyst_sel_o  = neg_hyst_sel_ff;
  assign resp_time_sel_o = resp_time_sel_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Synchroniser, edge flags

  // Gate the input so a powered-down front end yields no edges
  wire raw_gated = cmp_result_i & cmp_enable_bit_ff;

  cmp_sync_edge u_sync (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .raw_i   (raw_gated),
    .ev      (ev)
  );

  // Spurious edges after mode changes are flagged like real ones
  cmp_flags u_flags (
    .clock_i     (clock_i),
    .rst_n_i     (rst_n_i),
    .ev          (ev),
    .clr_rise_i  (wr_ctl),
    .clr_fall_i  (wr_ctl),
    .wr_rise_i   (wval[CTL_RISE_BIT]),
    .wr_fall_i   (wval[CTL_FALL_BIT]),
    .rise_flag_o (rise_edge_flag),
    .fall_flag_o (fall_edge_flag)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Raw path is combinational so it works with the clock stopped
  assign cmp_raw_out_o  = raw_gated;
  assign cmp_sync_out_o = ev.sync_level & cmp_enable_bit_ff;
  assign cmp_irq_o      = (rise_edge_flag & rise_irq_en_ff) |
                          (fall_edge_flag & fall_irq_en_ff);

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  wire [7:0] ctl_rd = {cmp_enable_bit_ff, ev.sync_level, rise_edge_flag,
                       fall_edge_flag, pos_hyst_sel_ff, neg_hyst_sel_ff};
  wire [7:0] mode_rd = {2'b00, rise_irq_en_ff, fall_irq_en_ff, 2'b00,
                        resp_time_sel_ff};
  wire [7:0] rd_sel = sel_ctl ? ctl_rd : (sel_mode ? mode_rd : 8'h00);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= {24'h00_0000, rd_sel};
    end
  end

  assign avs_readdata_o = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  // Pin outputs, synchroniser and edge flags

  a_sync_low_disabled: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !cmp_enable_bit_ff |-> !cmp_sync_out_o && !cmp_raw_out_o)
    else $error("port output high while disabled");

  a_raw_follows: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    cmp_enable_bit_ff |-> cmp_raw_out_o == cmp_result_i)
    else $error("raw output does not follow the result");

  a_rise_sets_flag: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ev.rise_pulse |=> rise_edge_flag)
    else $error("rising edge did not set flag");

  a_fall_sets_flag: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ev.fall_pulse |=> fall_edge_flag)
    else $error("falling edge did not set flag");

  a_flag_sticky: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    rise_edge_flag && !wr_ctl |=> rise_edge_flag)
    else $error("rising flag dropped without a write");

  a_fall_sticky: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    fall_edge_flag && !wr_ctl |=> fall_edge_flag)
    else $error("falling flag dropped without a write");

  a_rise_clear: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    wr_ctl && !wval[CTL_RISE_BIT] && !ev.rise_pulse |=> !rise_edge_flag)
    else $error("rising flag not cleared by write");

  a_fall_clear: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    wr_ctl && !wval[CTL_FALL_BIT] && !ev.fall_pulse |=> !fall_edge_flag)
    else $error("falling flag not cleared by write");

  a_sync_two_stage: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    $rose(raw_gated) ##1 raw_gated |=> ev.sync_level)
    else $error("synchroniser latency wrong");

  a_sync_fall_two: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    $fell(raw_gated) ##1 !raw_gated |=> !ev.sync_level)
    else $error("synchroniser fall latency wrong");

  // Interrupt request

  a_irq_rise_gate: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    cmp_irq_o |-> (rise_edge_flag && rise_irq_en_ff) ||
                  (fall_edge_flag && fall_irq_en_ff))
    else $error("interrupt without enabled flag");

  a_irq_fall_raise: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    fall_edge_flag && fall_irq_en_ff |-> cmp_irq_o)
    else $error("enabled falling flag gave no interrupt");

  a_rise_irq_fire: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ev.rise_pulse && rise_irq_en_ff && !wr_mode |=> cmp_irq_o)
    else $error("enabled rising edge gave no interrupt");

  a_fall_irq_fire: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ev.fall_pulse && fall_irq_en_ff && !wr_mode |=> cmp_irq_o)
    else $error("enabled falling edge gave no interrupt");

  a_irq_masked: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !rise_irq_en_ff && !fall_irq_en_ff |-> !cmp_irq_o)
    else $error("interrupt while both enables are off");

  // Register file and bus timing

  a_enable_lands: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    wr_ctl |=> cmp_enable_bit_ff == $past(wval[CTL_EN_BIT]))
    else $error("enable write did not land");

  a_hyst_lands: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    wr_ctl |=> pos_hyst_sel_ff == $past(wval[CTL_HYP_LSB +: 2]) &&
               neg_hyst_sel_ff == $past(wval[CTL_HYN_LSB +: 2]))
    else $error("hysteresis write did not land");

  a_resp_lands: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    wr_mode |=> resp_time_sel_ff == $past(wval[MD_RESP_LSB +: 2]))
    else $error("response time write did not land");

  a_ctl_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !wr_ctl |=> $stable({cmp_enable_bit_ff, pos_hyst_sel_ff, neg_hyst_sel_ff}))
    else $error("control settings changed without a write");

  a_mode_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !wr_mode |=> $stable({rise_irq_en_ff, fall_irq_en_ff, resp_time_sel_ff}))
    else $error("mode settings changed without a write");

  a_byte_gate: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    avs_write_i && !avs_byteenable_i[0] |=> $stable({cmp_enable_bit_ff, resp_time_sel_ff}))
    else $error("write without low byte enable changed a register");

  a_state_readback: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    sel_ctl |=> avs_readdata_o[CTL_STATE_BIT] == $past(ev.sync_level))
    else $error("state bit read back wrong");

  a_flag_readback: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    sel_ctl |=> avs_readdata_o[CTL_RISE_BIT] == $past(rise_edge_flag) &&
                avs_readdata_o[CTL_FALL_BIT] == $past(fall_edge_flag))
    else $error("edge flags read back wrong");

  a_resp_readback: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    sel_mode |=> avs_readdata_o[MD_RESP_LSB +: 2] == $past(resp_time_sel_ff))
    else $error("response time read back wrong");

  a_unused_zero: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    sel_mode |=> avs_readdata_o[7:6] == 2'b00 && avs_readdata_o[3:2] == 2'b00)
    else $error("unused mode bits read nonzero");

  a_high_zero: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    avs_readdata_o[31:8] == 24'h00_0000)
    else $error("upper read data bits nonzero");

  a_unmapped_zero: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !mapped |=> avs_readdata_o == 32'h0000_0000)
    else $error("unmapped address read nonzero");

  a_unmapped_err: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    req && !mapped |-> avs_response_o == 2'b10)
    else $error("unmapped access gave no error response");

  a_wait_one: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    $rose(req) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("waitrequest timing wrong");

  a_wait_short: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("waitrequest held for two cycles");

endmodule
`default_nettype wire

// ===== hdl/cmp_flags.sv
// Sticky edge flags with software clear; set wins over clear
`default_nettype none
module cmp_flags
  import cmp_pkg::*;
(
  input  wire logic  clock_i,
  input  wire logic  rst_n_i,
  edge_if.consumer   ev,
  input  wire logic  clr_rise_i,
  input  wire logic  clr_fall_i,
  input  wire logic  wr_rise_i,
  input  wire logic  wr_fall_i,
  output logic       rise_flag_o,
  output logic       fall_flag_o
);
  logic rise_ff;
  logic fall_ff;
  logic nxt_rise;
  logic nxt_fall;

  // Software may also set a flag by writing one
  assign nxt_rise = ev.rise_pulse | (clr_rise_i ? wr_rise_i : rise_ff);
  assign nxt_fall = ev.fall_pulse | (clr_fall_i ? wr_fall_i : fall_ff);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rise_ff <= 1'b0;
      fall_ff <= 1'b0;
    end else begin
      rise_ff <= nxt_rise;
      fall_ff <= nxt_fall;
    end
  end

  assign rise_flag_o = rise_ff;
  assign fall_flag_o = fall_ff;
endmodule
`default_nettype wire

// ===== hdl/cmp_sync_edge.sv
// Two-stage synchroniser and edge detector for the raw comparator result
`default_nettype none
module cmp_sync_edge
  import cmp_pkg::*;
(
  input  wire logic  clock_i,
  input  wire logic  rst_n_i,
  input  wire logic  raw_i,
  edge_if.producer   ev
);
  logic meta_ff;
  logic sync_ff;
  logic prev_ff;

  // Only sync_ff reads meta_ff
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      meta_ff <= raw_i;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign ev.sync_level = sync_ff;
  assign ev.rise_pulse = sync_ff & ~prev_ff;
  assign ev.fall_pulse = ~sync_ff & prev_ff;
endmodule
`default_nettype wire

// ===== tb/cmp_front_model.sv
// Behavioural analog comparator front end
`default_nettype none
module cmp_front_model (
  input  wire logic       level_i,
  input  wire logic       power_en_i,
  input  wire logic [1:0] resp_i,
  output logic            result_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic settled;
  initial begin
    result_o = 1'b0;
    settled  = 1'b0;
  end
  // Slower response settings take longer to settle
  always @(level_i) begin
    settled <= #(10 * (int'(resp_i) + 1)) level_i;
  end
  // Unpowered output means nothing, so it chatters; changes land on
  // falling clock edges so no flop ever races the input
  always begin
    #10;
    result_o = power_en_i ? settled : ~result_o;
  end
endmodule
`default_nettype wire

// ===== tb/voltage_comparator_control_test.sv
// Register, edge flag and pin output tests of the comparator control block
`default_nettype none
module voltage_comparator_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  import cmp_pkg::*;
  logic        clock_i = 1'b0;
  logic        rst_n_i;
  logic [3:0]  adr;
  logic        rd;
  logic        wr;
  logic [31:0] wdat;
  logic [3:0]  be;
  logic [31:0] rdat;
  logic        wreq;
  logic [1:0]  resp;
  logic        res;
  logic        pwr;
  logic [1:0]  hyp;
  logic [1:0]  hyn;
  logic [1:0]  rts;
  logic        sync_out;
  logic        raw_out;
  logic        irq;
  logic        level;
  logic [7:0]  got;
  logic [1:0]  gresp;
  int          failures;
  int          num_checks;

  cmp_ctrl cmp_ctrl_i (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .avs_response_o(resp), .cmp_result_i(res),
    .cmp_power_en_o(pwr), .pos_hyst_sel_o(hyp), .neg_hyst_sel_o(hyn),
    .resp_time_sel_o(rts), .cmp_sync_out_o(sync_out), .cmp_raw_out_o(raw_out), .cmp_irq_o(irq)
  );
  cmp_front_model cmp_front_model_i (
    .level_i(level), .power_en_i(pwr), .resp_i(rts), .result_o(res)
  );

  always #5 clock_i = ~clock_i;

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t ns: got %h, expected %h", $time, g, e);
    end
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task automatic access(input logic w, input logic [3:0] a, input logic [7:0] d,
                        input logic [3:0] b);
    @(posedge clock_i);
    adr  <= a;
    wdat <= {24'h000000, d};
    be   <= b;
    wr   <= w;
    rd   <= ~w;
    do @(posedge clock_i); while (wreq !== 1'b0);
    got   = rdat[7:0];
    gresp = resp;
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    access(1'b1, a, d, 4'hF);
  endtask

  task automatic reg_read(input logic [3:0] a);
    access(1'b0, a, 8'h00, 4'hF);
  endtask

  // Lets the front end and the two-flop synchroniser settle
  task automatic settle;
    repeat (10) @(posedge clock_i);
    #1;
  endtask

  task automatic complete_run;
    $display("checks %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #20000;
    failures++;
    complete_run();
  end

  initial begin
    rst_n_i    = 1'b0;
    adr        = 4'h0;
    rd         = 1'b0;
    wr         = 1'b0;
    wdat       = 32'h00000000;
    be         = 4'h0;
    level      = 1'b0;
    failures   = 0;
    num_checks = 0;
    repeat (16) @(posedge clock_i);
    rst_n_i <= 1'b1;
    reg_read(CONTROL_ADDR);
    chk(got, CONTROL_RST);
    chk({6'h00, gresp}, 8'h00);
    reg_read(MODE_ADDR);
    chk(got, MODE_RST);
    reg_write(MODE_ADDR, 8'hFF);
    reg_read(MODE_ADDR);
    chk(got, 8'h33);
    reg_write(CONTROL_ADDR, 8'h7F);
    reg_read(CONTROL_ADDR);
    chk(got, 8'h3F);
    reg_write(CONTROL_ADDR, 8'h0F);
    reg_read(CONTROL_ADDR);
    chk(got, 8'h0F);
    for (int i = 0; i < 4; i++) begin
      reg_write(CONTROL_ADDR, 8'(i * 4 + 3 - i));
      chk({6'h00, hyp}, 8'(i));
      chk({6'h00, hyn}, 8'(3 - i));
      reg_write(MODE_ADDR, 8'(i));
      chk({6'h00, rts}, 8'(i));
    end
    repeat (3) begin
      @(negedge clock_i);
      chk({6'h00, raw_out, sync_out}, 8'h00);
    end
    $display("test registers done");
    reg_write(CONTROL_ADDR, 8'h80);
    chk({7'h00, pwr}, 8'h01);
    settle();
    reg_write(CONTROL_ADDR, 8'h80);
    level <= 1'b1;
    settle();
    chk({6'h00, raw_out, sync_out}, 8'h03);
    chk({7'h00, irq}, 8'h00);
    reg_read(CONTROL_ADDR);
    chk(got, 8'hE0);
    reg_write(MODE_ADDR, 8'h23);
    chk({7'h00, irq}, 8'h01);
    reg_write(CONTROL_ADDR, 8'h80);
    chk({7'h00, irq}, 8'h00);
    level <= 1'b0;
    settle();
    settle();
    reg_read(CONTROL_ADDR);
    chk(got, 8'h90);
    chk({7'h00, irq}, 8'h00);
    reg_write(MODE_ADDR, 8'h13);
    chk({7'h00, irq}, 8'h01);
    $display("test edges done");
    reg_write(CONTROL_ADDR, 8'h80);
    level <= 1'b1;
    settle();
    reg_write(CONTROL_ADDR, 8'h00);
    chk({6'h00, raw_out, pwr}, 8'h00);
    settle();
    chk({7'h00, sync_out}, 8'h00);
    reg_read(CONTROL_ADDR);
    chk(got, 8'h10);
    reg_read(4'h8);
    chk({gresp, got[5:0]}, 8'h80);
    access(1'b1, CONTROL_ADDR, 8'h8F, 4'h0);
    reg_read(CONTROL_ADDR);
    chk(got, 8'h10);
    $display("test disable done");
    complete_run();
  end
endmodule
`default_nettype wire
